// ==== common/rxs_pkg.sv ====
// Purpose: Constants and types shared by the receive status word block.
// Assumes: One clock and an active-low asynchronous reset.
// Notes:   Register offsets are byte addresses on the AHB-Lite bus.
package rxs_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [7:0]  RXS_ADDR_MODE     = 8'h00;
  localparam logic [7:0]  RXS_ADDR_STAT     = 8'h04;
  localparam logic [7:0]  RXS_ADDR_MASK     = 8'h08;
  localparam logic [7:0]  RXS_ADDR_WORD     = 8'h0C;
  localparam int          RXS_MODE_PASS_BAD = 3;
  localparam int          RXS_MODE_LOOP_LO  = 10;
  localparam int          RXS_ST_DONE       = 0;
  localparam int          RXS_ST_OVERRUN    = 1;
  localparam int          RXS_ST_WDOG       = 9;
  localparam logic [31:0] RXS_MODE_RST      = 32'h0000_0000;
  localparam logic [31:0] RXS_STAT_RST      = 32'h0000_0000;
  localparam logic [31:0] RXS_MASK_RST      = 32'h0000_0000;

  // ************************************************************
  // Frame constants
  // ************************************************************
  localparam logic [1:0]  RXS_LOOP_INT    = 2'h1;
  localparam logic [1:0]  RXS_LOOP_EXT    = 2'h2;
  localparam logic [1:0]  RXS_DT_SERIAL   = 2'h0;
  localparam logic [1:0]  RXS_DT_INT      = 2'h1;
  localparam logic [1:0]  RXS_DT_EXT      = 2'h2;
  localparam logic [14:0] RXS_MAX_FRAME   = 15'h05EE;
  localparam logic [14:0] RXS_COLL_WIN    = 15'h0040;
  localparam logic [14:0] RXS_WDOG_BYTES  = 15'h0800;
  localparam logic [14:0] RXS_TYPE_HDR    = 15'h000E;
  localparam logic [14:0] RXS_BYTE_LT_HI  = 15'h000C;
  localparam logic [14:0] RXS_BYTE_LT_LO  = 15'h000D;
  localparam logic [15:0] RXS_TYPE_MIN    = 16'h05DC;
  localparam logic [2:0]  RXS_DRIB_MIN    = 3'h2;
  localparam logic [31:0] RXS_CRC_INIT    = 32'hFFFF_FFFF;
  localparam logic [31:0] RXS_CRC_POLY    = 32'hEDB8_8320;
  localparam logic [31:0] RXS_CRC_RESIDUE = 32'hDEBB_20E3;

  typedef enum logic [1:0] {
    RXS_S_FILL = 2'b00,
    RXS_S_LAST = 2'b01,
    RXS_S_DROP = 2'b11
  } rxs_state_t;

  typedef struct packed {
    logic [7:0] data;
    logic       eop;
    logic [2:0] extra_bits;
  } rxs_rx_byte_t;

  typedef struct packed {
    logic [10:0] buf1_size;
    logic [10:0] buf2_size;
  } rxs_desc_t;

  typedef struct packed {
    logic        desc_owned;
    logic [14:0] rx_length_field;
    logic        error_or_flag;
    logic        len_error_flag;
    logic [1:0]  frame_source_type;
    logic        short_frame_flag;
    logic        group_addr_flag;
    logic        first_desc_flag;
    logic        last_desc_flag;
    logic        oversize_flag;
    logic        late_coll_flag;
    logic        length_type_flag;
    logic        rx_timer_expired_flag;
    logic        rsvd;
    logic        extra_bits_flag;
    logic        crc_error_flag;
    logic        fifo_overrun_flag;
  } rxs_status_word_t;

endpackage : rxs_pkg

// ==== hw/rxs_crc.sv ====
// Purpose: Running CRC-32 over the whole bytes of a received frame.
// Assumes: Reflected polynomial; a start byte restarts the sum.
// Notes:   After the frame check bytes the sum equals the residue.
`timescale 1ns/10ps
module rxs_crc (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        start,
  input  wire logic        en,
  input  wire logic [7:0]  data,
  output logic      [31:0] crc
);

  typedef struct packed {
    logic [31:0] crc;
  } rxs_crc_st_t;

  rxs_crc_st_t q;
  rxs_crc_st_t d;

  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] b);
    logic [31:0] r;
    r = c ^ {24'h00_0000, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ rxs_pkg::RXS_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : crc_byte

  always_comb begin
    d = q;
    if (en) begin
      d.crc = crc_byte(start ? rxs_pkg::RXS_CRC_INIT : q.crc, data);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '{crc: rxs_pkg::RXS_CRC_INIT};
    end else begin
      q <= d;
    end
  end

  assign crc = q.crc;

endmodule : rxs_crc

// ==== hw/rxs_regs.sv ====
// Purpose: AHB-Lite register slave with sticky status and interrupt.
// Assumes: Zero wait states; single word transfers.
// Notes:   Status bits clear on writing one; a set in the same cycle wins.
`timescale 1ns/10ps
module rxs_regs (
  input  wire logic                      hclk,
  input  wire logic                      hresetn,
  input  wire logic                      hsel,
  input  wire logic [31:0]               haddr,
  input  wire logic [1:0]                htrans,
  input  wire logic                      hwrite,
  input  wire logic [31:0]               hwdata,
  input  wire logic                      hready,
  output logic                           hreadyout,
  output logic      [31:0]               hrdata,
  output logic                           hresp,
  input  wire logic [31:0]               ev_set,
  input  wire rxs_pkg::rxs_status_word_t last_word,
  output logic      [31:0]               mode,
  output logic                           irq
);

  typedef struct packed {
    logic        wr;
    logic [7:0]  addr;
    logic [31:0] mode;
    logic [31:0] stat;
    logic [31:0] mask;
    logic [31:0] rdata;
  } rxs_regs_st_t;

  rxs_regs_st_t q;
  rxs_regs_st_t d;

  always_comb begin
    d = q;
    if (q.wr) begin
      unique case (q.addr)
        rxs_pkg::RXS_ADDR_MODE: d.mode = hwdata;
        rxs_pkg::RXS_ADDR_STAT: d.stat = q.stat & ~hwdata;
        rxs_pkg::RXS_ADDR_MASK: d.mask = hwdata;
        default:                d.wr   = 1'b0;
      endcase
    end
    d.stat = d.stat | ev_set;
    d.wr   = 1'b0;
    if (hsel && hready && htrans[1]) begin
      d.wr   = hwrite;
      d.addr = haddr[7:0];
      unique case (haddr[7:0])
        rxs_pkg::RXS_ADDR_MODE: d.rdata = d.mode;
        rxs_pkg::RXS_ADDR_STAT: d.rdata = d.stat;
        rxs_pkg::RXS_ADDR_MASK: d.rdata = d.mask;
        rxs_pkg::RXS_ADDR_WORD: d.rdata = last_word;
        default:                d.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '{wr: 1'b0, addr: 8'h00, mode: rxs_pkg::RXS_MODE_RST,
             stat: rxs_pkg::RXS_STAT_RST, mask: rxs_pkg::RXS_MASK_RST,
             rdata: 32'h0000_0000};
    end else begin
      q <= d;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = q.rdata;
  assign mode      = q.mode;
  assign irq       = |(q.stat & q.mask);

endmodule : rxs_regs

// ==== hw/rxs_status_word.sv ====
// Purpose: Builds the receive status word for each receive descriptor.
// Assumes: Bytes arrive from the receive MAC synchronous to hclk.
// Notes:   A descriptor is loaded after desc_req asked for it, except the first one after reset.
//
// Notes on behaviour
// - Source type from loop mode, never 11.
// - Frame fields guaranteed on last descriptor only.
// - Runt flagged; dropped unless pass-bad set or overrun seen.
// - Runt flag meaningful on last, no overrun.
// - Group flag from destination address bit.
// - First flag marks descriptor with first byte.
// - Last flag marks descriptor with final bytes.
// - Oversize when length exceeds 1518 bytes.
// - Late collision after first 64 bytes.
// - Type flag when length/type exceeds 1500.
// - Watchdog flag and status bit at 2048.
// - Extra bits flag when above two bits.
// - CRC over whole bytes only.
// - Overrun flag on receive FIFO overflow.
// - Ownership cleared when descriptor handed back.
// - Error summary ORs the error flags.
// - Length field counts bytes including CRC.
`timescale 1ns/10ps
module rxs_status_word (
  input  wire logic                      hclk,
  input  wire logic                      hresetn,
  input  wire logic                      hsel,
  input  wire logic [31:0]               haddr,
  input  wire logic [1:0]                htrans,
  input  wire logic                      hwrite,
  input  wire logic [2:0]                hsize,
  input  wire logic [31:0]               hwdata,
  input  wire logic                      hready,
  output logic                           hreadyout,
  output logic      [31:0]               hrdata,
  output logic                           hresp,
  input  wire logic                      rx_valid,
  input  wire rxs_pkg::rxs_rx_byte_t     rx_in,
  output logic                           rx_ready,
  input  wire logic                      rx_collision,
  input  wire logic                      rx_overflow,
  input  wire logic                      desc_load,
  input  wire rxs_pkg::rxs_desc_t        desc_in,
  input  wire logic                      desc_none,
  output logic                           desc_req,
  output logic                           sw_valid,
  output rxs_pkg::rxs_status_word_t      sw_word,
  output logic                           frame_discard,
  output logic                           irq
);

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    rxs_pkg::rxs_state_t       st;
    logic                      have;
    logic [11:0]               room;
    logic [11:0]               cap;
    logic                      used;
    logic                      first;
    logic [14:0]               cnt;
    logic [7:0]                lt_hi;
    logic                      lt_big;
    logic                      grp;
    logic                      early;
    logic                      late;
    logic                      ovr;
    logic                      wdog;
    logic                      eop;
    logic                      trunc;
    logic [2:0]                drib;
    logic                      sw_valid;
    rxs_pkg::rxs_status_word_t sw;
    logic                      discard;
    logic                      req;
    logic [31:0]               ev;
  } rxs_main_st_t;

  rxs_main_st_t              q;
  rxs_main_st_t              d;
  logic                      take;
  logic [31:0]               crc;
  logic [31:0]               mode;
  logic                      pass_bad;
  logic [1:0]                loop_mode;
  rxs_pkg::rxs_status_word_t last_w;

  assign pass_bad  = mode[rxs_pkg::RXS_MODE_PASS_BAD];
  assign loop_mode = mode[rxs_pkg::RXS_MODE_LOOP_LO +: 2];

  // ************************************************************
  // Word builders
  // ************************************************************
  function automatic logic [1:0] src_type(input logic [1:0] lm);
    unique case (lm)
      rxs_pkg::RXS_LOOP_INT: src_type = rxs_pkg::RXS_DT_INT;
      rxs_pkg::RXS_LOOP_EXT: src_type = rxs_pkg::RXS_DT_EXT;
      default:               src_type = rxs_pkg::RXS_DT_SERIAL;
    endcase
  endfunction : src_type

  function automatic rxs_pkg::rxs_status_word_t part_word(input logic first);
    rxs_pkg::rxs_status_word_t w;
    w                 = '0;
    w.first_desc_flag = first;
    return w;
  endfunction : part_word

  function automatic rxs_pkg::rxs_status_word_t build_last(
      input rxs_main_st_t s, input logic [1:0] lm, input logic [31:0] c);
    rxs_pkg::rxs_status_word_t w;
    logic                      short;
    w     = '0;
    short = s.early | (s.eop & (s.cnt < rxs_pkg::RXS_COLL_WIN));
    w.rx_length_field       = s.cnt;
    w.len_error_flag        = s.trunc;
    w.frame_source_type     = src_type(lm);
    w.short_frame_flag      = short & ~s.ovr;
    w.group_addr_flag       = s.grp;
    w.first_desc_flag       = s.first;
    w.last_desc_flag        = 1'b1;
    w.oversize_flag         = s.cnt > rxs_pkg::RXS_MAX_FRAME;
    w.late_coll_flag        = s.late;
    w.length_type_flag      = s.lt_big & (s.cnt >= rxs_pkg::RXS_TYPE_HDR);
    w.rx_timer_expired_flag = s.wdog;
    w.extra_bits_flag       = s.eop & (s.drib > rxs_pkg::RXS_DRIB_MIN)
                              & ~s.late & ~short;
    w.crc_error_flag        = s.eop & (c != rxs_pkg::RXS_CRC_RESIDUE);
    w.fifo_overrun_flag     = s.ovr;
    w.error_or_flag         = w.fifo_overrun_flag | w.crc_error_flag
                              | w.late_coll_flag | w.oversize_flag
                              | short | w.len_error_flag;
    return w;
  endfunction : build_last

  assign last_w = build_last(q, loop_mode, crc);

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    d          = q;
    take       = 1'b0;
    d.sw_valid = 1'b0;
    d.discard  = 1'b0;
    d.req      = 1'b0;
    d.ev       = 32'h0000_0000;
    if (desc_load) begin
      d.have  = 1'b1;
      d.room  = {1'b0, desc_in.buf1_size} + {1'b0, desc_in.buf2_size};
      d.cap   = d.room;
      d.used  = 1'b0;
      d.first = 1'b0;
    end
    if (rx_overflow && q.st == rxs_pkg::RXS_S_FILL) begin
      d.ovr = 1'b1;
    end
    unique case (q.st)
      rxs_pkg::RXS_S_FILL: begin
        if (q.have && q.room == 12'h000 && !q.used) begin
          // Both buffers empty: hand back, the frame starts in the next one.
          d.sw                 = part_word(1'b0);
          d.sw_valid           = 1'b1;
          d.have               = 1'b0;
          d.req                = 1'b1;
          d.ev[rxs_pkg::RXS_ST_DONE] = 1'b1;
        end else if (q.have && q.room == 12'h000 && rx_valid) begin
          if (desc_none) begin
            d.trunc = 1'b1;
            d.st    = rxs_pkg::RXS_S_LAST;
          end else begin
            d.sw                 = part_word(q.first);
            d.sw_valid           = 1'b1;
            d.have               = 1'b0;
            d.req                = 1'b1;
            d.used               = 1'b0;
            d.first              = 1'b0;
            d.ev[rxs_pkg::RXS_ST_DONE] = 1'b1;
          end
        end else if (rx_valid && rx_ready) begin
          take   = 1'b1;
          d.cnt  = q.cnt + 15'h0001;
          d.room = q.room - 12'h001;
          d.used = 1'b1;
          if (q.cnt == 15'h0000) begin
            d.first = 1'b1;
            d.grp   = rx_in.data[0];
          end
          if (q.cnt == rxs_pkg::RXS_BYTE_LT_HI) begin
            d.lt_hi = rx_in.data;
          end
          if (q.cnt == rxs_pkg::RXS_BYTE_LT_LO) begin
            d.lt_big = {q.lt_hi, rx_in.data} > rxs_pkg::RXS_TYPE_MIN;
          end
          if (rx_collision) begin
            if (q.cnt < rxs_pkg::RXS_COLL_WIN) begin
              d.early = 1'b1;
            end else begin
              d.late = 1'b1;
            end
          end
          if (rx_in.eop) begin
            d.eop  = 1'b1;
            d.drib = rx_in.extra_bits;
            d.st   = rxs_pkg::RXS_S_LAST;
          end else if (d.cnt == rxs_pkg::RXS_WDOG_BYTES) begin
            d.wdog = 1'b1;
            d.st   = rxs_pkg::RXS_S_LAST;
          end
        end
      end
      rxs_pkg::RXS_S_LAST: begin
        if (last_w.short_frame_flag && !pass_bad) begin
          // Runt kept back: the descriptor is reused from its start.
          d.discard = 1'b1;
          d.room    = q.cap;
          d.used    = 1'b0;
          d.first   = 1'b0;
        end else begin
          d.sw       = last_w;
          d.sw_valid = 1'b1;
          d.have     = 1'b0;
          d.req      = 1'b1;
          d.ev[rxs_pkg::RXS_ST_DONE]    = 1'b1;
          d.ev[rxs_pkg::RXS_ST_OVERRUN] = q.ovr;
          d.ev[rxs_pkg::RXS_ST_WDOG]    = q.wdog;
        end
        d.cnt    = 15'h0000;
        d.lt_hi  = 8'h00;
        d.lt_big = 1'b0;
        d.grp    = 1'b0;
        d.early  = 1'b0;
        d.late   = 1'b0;
        d.ovr    = 1'b0;
        d.wdog   = 1'b0;
        d.trunc  = 1'b0;
        d.eop    = 1'b0;
        d.drib   = 3'h0;
        d.st     = q.eop ? rxs_pkg::RXS_S_FILL : rxs_pkg::RXS_S_DROP;
      end
      rxs_pkg::RXS_S_DROP: begin
        if (rx_valid && rx_in.eop) begin
          d.st = rxs_pkg::RXS_S_FILL;
        end
      end
      default: d.st = rxs_pkg::RXS_S_FILL;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign rx_ready      = (q.st == rxs_pkg::RXS_S_DROP)
                         | ((q.st == rxs_pkg::RXS_S_FILL) & q.have & (q.room != 12'h000));
  assign sw_valid      = q.sw_valid;
  assign sw_word       = q.sw;
  assign desc_req      = q.req;
  assign frame_discard = q.discard;

  // ************************************************************
  // Submodules
  // ************************************************************
  rxs_crc u_crc (
    .hclk    (hclk),
    .hresetn (hresetn),
    .start   (take && q.cnt == 15'h0000),
    .en      (take),
    .data    (rx_in.data),
    .crc     (crc)
  );

  rxs_regs u_regs (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hwdata    (hwdata),
    .hready    (hready),
    .hreadyout (hreadyout),
    .hrdata    (hrdata),
    .hresp     (hresp),
    .ev_set    (q.ev),
    .last_word (q.sw),
    .mode      (mode),
    .irq       (irq)
  );

  // ************************************************************
  // Assertions
  // ************************************************************
  a_type_code: assert property (
    @(posedge hclk) disable iff (!hresetn)
    q.sw_valid |-> q.sw.frame_source_type != 2'h3)
    else $error("Source type code 11 produced.");

  a_part_clean: assert property (
    @(posedge hclk) disable iff (!hresetn)
    q.sw_valid && !q.sw.last_desc_flag |-> q.sw[30:10] == 21'h000000 && q.sw[8:0] == 9'h000)
    else $error("Frame fields set on a non-last descriptor.");

  a_runt_drop: assert property (
    @(posedge hclk) disable iff (!hresetn)
    q.st == rxs_pkg::RXS_S_LAST && last_w.short_frame_flag && !pass_bad
    |=> q.discard && !q.sw_valid)
    else $error("Runt frame written while pass-bad is clear.");

  a_empty_desc: assert property (
    @(posedge hclk) disable iff (!hresetn)
    q.st == rxs_pkg::RXS_S_FILL && q.have && q.room == 12'h000 && !q.used
    |=> q.sw_valid && !q.sw.first_desc_flag && !q.sw.last_desc_flag)
    else $error("Empty descriptor not handed back plainly.");

  a_eop_last: assert property (
    @(posedge hclk) disable iff (!hresetn)
    take && rx_in.eop |=> q.st == rxs_pkg::RXS_S_LAST
    ##1 ((q.sw_valid && q.sw.last_desc_flag) || q.discard))
    else $error("End of frame did not close with a last word.");

  a_too_long: assert property (
    @(posedge hclk) disable iff (!hresetn)
    q.sw_valid && q.sw.last_desc_flag
    |-> q.sw.oversize_flag == (q.sw.rx_length_field > rxs_pkg::RXS_MAX_FRAME))
    else $error("Oversize flag disagrees with the length.");

  a_wdog_len: assert property (
    @(posedge hclk) disable iff (!hresetn)
    q.sw_valid && q.sw.rx_timer_expired_flag
    |-> q.sw.rx_length_field == rxs_pkg::RXS_WDOG_BYTES && q.ev[rxs_pkg::RXS_ST_WDOG])
    else $error("Watchdog flag without its length or status bit.");

  a_drib_valid: assert property (
    @(posedge hclk) disable iff (!hresetn)
    q.sw_valid && q.sw.extra_bits_flag
    |-> !q.sw.late_coll_flag && !q.sw.short_frame_flag && $past(q.drib) > rxs_pkg::RXS_DRIB_MIN)
    else $error("Extra bits flag set where it is not valid.");

  a_own_clear: assert property (
    @(posedge hclk) disable iff (!hresetn)
    q.sw_valid |-> !q.sw.desc_owned ##1 !q.have)
    else $error("Descriptor returned while still owned.");

endmodule : rxs_status_word

// ==== bench/rxs_host_model.sv ====
// Purpose: Host side that hands receive descriptors to the status block.
// Assumes: One descriptor per request, answered one to four cycles after the request is seen.
// Notes:   Buffer sizes come from the bench.
`timescale 1ns/10ps
module rxs_host_model (
  input  wire logic               hclk,
  input  wire logic               hresetn,
  input  wire logic               desc_req,
  input  wire rxs_pkg::rxs_desc_t sz,
  output logic                    desc_load,
  output rxs_pkg::rxs_desc_t      desc_in
);
  logic       pend;
  logic [1:0] cnt;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      desc_load <= 1'b0;
      desc_in   <= '0;
      pend      <= 1'b1;
      cnt       <= 2'h0;
    end else begin
      desc_load <= 1'b0;
      if (desc_req) begin
        pend <= 1'b1;
        cnt  <= 2'($urandom_range(3, 0));
      end else if (pend && cnt == 2'h0) begin
        desc_load <= 1'b1;
        desc_in   <= sz;
        pend      <= 1'b0;
      end else if (pend) begin
        cnt <= cnt - 2'h1;
      end
    end
  end
endmodule : rxs_host_model

// ==== bench/tb_top.sv ====
// Purpose: Self-checking bench for the receive status word block.
// Assumes: Zero wait AHB-Lite slave; host model answers descriptor requests.
// Notes:   Expected words come from the frame parameters the bench chose.
`timescale 1ns/10ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin failures++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
  logic                      hclk, hresetn, hsel, hwrite, hreadyout, hresp, rx_valid;
  logic                      rx_ready, rx_collision, rx_overflow, desc_load, desc_none;
  logic                      desc_req, sw_valid, frame_discard, irq;
  logic [31:0]               haddr, hwdata, hrdata, rd;
  logic [1:0]                htrans, loop;
  logic [2:0]                hsize;
  rxs_pkg::rxs_rx_byte_t     rx_in;
  rxs_pkg::rxs_desc_t        desc_in, sz;
  rxs_pkg::rxs_status_word_t sw_word;
  rxs_pkg::rxs_status_word_t wq[$];
  int                        failures, n_tests, ndisc;

  rxs_status_word dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .rx_valid(rx_valid), .rx_in(rx_in),
    .rx_ready(rx_ready), .rx_collision(rx_collision), .rx_overflow(rx_overflow),
    .desc_load(desc_load), .desc_in(desc_in), .desc_none(desc_none), .desc_req(desc_req),
    .sw_valid(sw_valid), .sw_word(sw_word), .frame_discard(frame_discard), .irq(irq));
  rxs_host_model host (.hclk(hclk), .hresetn(hresetn), .desc_req(desc_req), .sz(sz),
    .desc_load(desc_load), .desc_in(desc_in));

  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  always @(posedge hclk) begin
    if (sw_valid === 1'b1) wq.push_back(sw_word);
    if (frame_discard === 1'b1) ndisc++;
  end

  task automatic finish_test();
    $display("checks=%0d mismatches=%0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0; hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb

  task automatic setmode(input logic [1:0] lp, input logic pb);
    loop = lp;
    ahb(1'b1, rxs_pkg::RXS_ADDR_MODE, {20'h0, lp, 6'h0, pb, 3'h0});
  endtask : setmode

  // Sends one frame with a correct or broken check sequence and compares the words.
  task automatic frame(input int len, coll, ov, x, input bit bad, wd, input int nw);
    logic [7:0] b[$];
    logic [31:0] c, m, w;
    logic [15:0] lt;
    rxs_pkg::rxs_status_word_t e;
    bit mc, runt;
    int d0, k;
    mc = 1'($urandom); lt = 16'($urandom); wq.delete(); d0 = ndisc; w = '0;
    for (int i = 0; i < len - 4; i++) b.push_back(8'($urandom));
    b[0][0] = mc; b[12] = lt[15:8]; b[13] = lt[7:0]; c = rxs_pkg::RXS_CRC_INIT;
    foreach (b[i]) begin
      c ^= {24'h0, b[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ rxs_pkg::RXS_CRC_POLY : c >> 1;
    end
    c = ~c ^ {31'h0, bad};
    for (int i = 0; i < 4; i++) b.push_back(c[8*i +: 8]);
    foreach (b[i]) begin
      rx_valid <= 1'b1; rx_collision <= (i == coll); rx_overflow <= (i == ov);
      rx_in <= '{b[i], i == len - 1, (i == len - 1) ? 3'(x) : 3'h0};
      do @(posedge hclk); while (rx_ready !== 1'b1);
    end
    rx_valid <= 1'b0; rx_collision <= 1'b0; rx_overflow <= 1'b0; k = 0;
    while ((wq.size() < nw || (nw == 0 && ndisc == d0)) && k < 400) begin
      @(posedge hclk); k++;
    end
    repeat (8) @(posedge hclk);
    runt = len < 64 || (coll >= 0 && coll < 64);
    e = '0; e.rx_length_field = 15'(len); e.short_frame_flag = runt && ov < 0;
    e.group_addr_flag = mc; e.first_desc_flag = nw == 1; e.last_desc_flag = 1'b1;
    e.oversize_flag = len > int'(rxs_pkg::RXS_MAX_FRAME); e.late_coll_flag = coll >= 64;
    e.length_type_flag = lt > rxs_pkg::RXS_TYPE_MIN; e.rx_timer_expired_flag = wd;
    e.extra_bits_flag = x > 2 && !runt && coll < 64; e.crc_error_flag = bad;
    e.fifo_overrun_flag = ov >= 0; e.frame_source_type = (loop == 2'h3) ? 2'h0 : loop;
    e.error_or_flag = e.fifo_overrun_flag | bad | e.late_coll_flag | e.oversize_flag | runt;
    e.len_error_flag = desc_none; e.error_or_flag |= desc_none;
    m = (nw == 0) ? 32'h0 : wd ? 32'h0000_0110 : (ov >= 0) ? 32'h8000_7FFD
        : desc_none ? 32'h8000_FFFF : 32'hFFFF_FFFF;
    if (nw > 0) w = wq[nw-1];
    `CHK(w & m & 32'hFFFF_F000, e & m & 32'hFFFF_F000)
    `CHK(w & m & 32'h0000_0FFF, e & m & 32'h0000_0FFF)
    if (nw == 2) `CHK(wq[0], 32'h0000_0200)
    if (nw == 0) `CHK(ndisc, d0 + 1)
  endtask : frame

  initial begin
    #160000;
    failures++;
    finish_test();
  end

  initial begin
    void'($urandom(23));
    hresetn = 1'b0; hsel = 1'b0; htrans = 2'h0; hwrite = 1'b0; hsize = 3'h2; haddr = '0;
    hwdata = '0; rx_valid = 1'b0; rx_in = '0; rx_collision = 1'b0; rx_overflow = 1'b0;
    desc_none = 1'b0; sz = {11'h7FF, 11'h7FF}; loop = 2'h0; failures = 0; n_tests = 0;
    ndisc = 0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      ahb(1'b0, 8'(4 * i), 32'h0);
      `CHK({hresp, rd}, 33'h0_0000_0000)
    end
    $display("test registers done");
    ahb(1'b1, rxs_pkg::RXS_ADDR_MASK, 32'h0000_0001);
    for (int i = 0; i < 4; i++) begin
      setmode(2'(i), 1'b0);
      frame($urandom_range(200, 64), -1, -1, 0, 0, 0, 1);
      `CHK(irq, 1'b1)
      ahb(1'b1, rxs_pkg::RXS_ADDR_STAT, 32'h0000_0001);
      @(posedge hclk);
      `CHK(irq, 1'b0)
    end
    $display("test modes done");
    ahb(1'b1, rxs_pkg::RXS_ADDR_MASK, 32'h0000_0000);
    setmode(2'h0, 1'b0);
    frame(1518, -1, -1, 0, 0, 0, 1);
    frame(1519, -1, -1, 0, 0, 0, 1);
    `CHK(irq, 1'b0)
    $display("test length done");
    setmode(2'h0, 1'b1);
    frame(100, 64, -1, 0, 0, 0, 1);
    frame(100, 63, -1, 0, 0, 0, 1);
    frame(40, -1, -1, 0, 0, 0, 1);
    setmode(2'h0, 1'b0);
    frame(40, -1, -1, 0, 0, 0, 0);
    $display("test collision done");
    frame(80, -1, -1, 3, 1, 0, 1);
    frame(80, -1, -1, 2, 1, 0, 1);
    frame(80, -1, -1, 0, 1, 0, 1);
    $display("test dribble done");
    frame(100, -1, 30, 0, 0, 0, 1);
    ahb(1'b0, rxs_pkg::RXS_ADDR_STAT, 32'h0);
    `CHK(rd[1:0], 2'h3)
    sz = '0;
    frame(90, -1, -1, 0, 0, 0, 1);
    `CHK(wq[1], 32'h0000_0000)
    sz = {11'h000, 11'h028};
    repeat (20) @(posedge hclk);
    frame(64, -1, -1, 0, 0, 0, 2);
    sz = {11'h7FF, 11'h7FF};
    desc_none <= 1'b1;
    frame(100, -1, -1, 0, 0, 0, 1);
    desc_none <= 1'b0;
    $display("test descriptors done");
    frame(2050, -1, -1, 0, 0, 1, 1);
    ahb(1'b0, rxs_pkg::RXS_ADDR_STAT, 32'h0);
    `CHK(rd[9], 1'b1)
    $display("test watchdog done");
    finish_test();
  end
endmodule : tb_top
